// File: src/cpd_top.sv
// Purpose: complementary pwm generator with programmable dead-time and a simple register port
// Assumes: single 40 MHz clock; rst_i is the hard init and must be pulsed after power-up
// Notes:   kill_n_i is asynchronous and is synchronised here; read data follow the strobe by one clock
`timescale 1ns/1ps
`include "cpd_cfg.svh"

////////////////////////////////////////////////////////////////////////////////////////////////////
module cpd_top (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic [1:0]         addr_i,
  input  wire cpd_pkg::cpd_byte_t wdata_i,
  input  wire logic               wr_i,
  input  wire logic               rd_i,
  input  wire logic               kill_n_i,
  output cpd_pkg::cpd_byte_t      rdata_o,
  output logic                    primary_drive_o,
  output logic                    complement_drive_o
);

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // comparator function, used by the datapath only; the checks restate the compare inline
  function automatic logic cpd_compare(input logic [7:0] cnt, input logic [7:0] duty, input logic res8);
    logic hit;
    hit = 1'b0;
    if (res8) begin
      // codes 0 and 1 give a flat low, all ones a flat high
      if (duty <= 8'h01) begin
        hit = 1'b0;
      end else if (duty == `CPD_CNT_TOP_8BIT) begin
        hit = 1'b1;
      end else begin
        hit = cnt < duty;
      end
    end else begin
      if (duty[7] || duty[6:0] == `CPD_CNT_TOP_7BIT) begin
        hit = 1'b1;
      end else if (duty[6:0] <= 7'h01) begin
        hit = 1'b0;
      end else begin
        hit = cnt[6:0] < duty[6:0];
      end
    end
    return hit;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // declarations
  cpd_pkg::cpd_byte_t ctrl;
  cpd_pkg::cpd_byte_t duty;
  cpd_pkg::cpd_byte_t duty_eff;
  logic               wr_ctrl;
  logic               wr_duty;
  logic               kill_meta;
  logic               kill_sync;
  logic               div_phase;
  logic               tick;
  logic [7:0]         count;
  logic               period_start;
  logic               raw;
  logic               prim;
  logic               comp;
  cpd_pkg::cpd_run_e  run_state;
  cpd_pkg::cpd_run_e  next_run_state;
  logic               enabled;
  logic               res8;
  logic               div;
  logic               stop;

  assign res8 = ctrl[`CPD_BIT_RES8];
  assign div  = ctrl[`CPD_BIT_DIV];
  assign stop = ctrl[`CPD_BIT_STOP];

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // register port decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_duty = 1'b0;
    if (wr_i && addr_i == `CPD_ADDR_DUTY) begin
      wr_duty = 1'b1;
    end else if (wr_i && addr_i == `CPD_ADDR_CTRL) begin
      wr_ctrl = 1'b1;
    end
  end

  // read data stand for one clock only, zero otherwise
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (!rd_i) begin
      rdata_o <= 8'h00;
    end else if (addr_i == `CPD_ADDR_DUTY) begin
      rdata_o <= duty;
    end else if (addr_i == `CPD_ADDR_CTRL) begin
      rdata_o <= ctrl;
    end else if (addr_i == `CPD_ADDR_STATUS) begin
      rdata_o <= {5'h00, enabled, kill_sync, raw};
    end else begin
      rdata_o <= count;
    end
  end

  cpd_ctrl_regs u_regs (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .wr_ctrl_i  (wr_ctrl),
    .wr_duty_i  (wr_duty),
    .wdata_i    (wdata_i),
    .ctrl_o     (ctrl),
    .duty_o     (duty),
    .duty_eff_o (duty_eff)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // kill input from a pin: two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kill_meta <= 1'b0;
      kill_sync <= 1'b0;
    end else begin
      kill_meta <= kill_n_i;
      kill_sync <= kill_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // prescaler: a tick every clock, or every second clock when dividing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_phase <= 1'b0;
    end else begin
      div_phase <= ~div_phase;
    end
  end
  assign tick = div ? div_phase : 1'b1;

  // pwm counter wraps at 127 or 255; >= guards a resolution change mid-period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 8'h00;
    end else if (tick) begin
      if (res8 ? (count == `CPD_CNT_TOP_8BIT) : (count >= `CPD_CNT_TOP_7BIT)) begin
        count <= 8'h00;
      end else begin
        count <= count + 8'h01;
      end
    end
  end
  assign period_start = tick && (count == 8'h00);

  // live compare against the pipe output, so a change lands mid-period
  assign raw = cpd_compare(count, duty_eff, res8);

  cpd_deadtime u_dt (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .raw_i  (raw),
    .code_i (ctrl[`CPD_DT_MSB:`CPD_DT_LSB]),
    .prim_o (prim),
    .comp_o (comp)
  );

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // output enable: off at once, back on only at a period start
  always_comb begin
    next_run_state = run_state;
    case (run_state)
      cpd_pkg::CPD_ST_STOPPED: begin
        if (stop && kill_sync && period_start) begin
          next_run_state = cpd_pkg::CPD_ST_RUNNING;
        end
      end
      cpd_pkg::CPD_ST_RUNNING: begin
        if (!stop || !kill_sync) begin
          next_run_state = cpd_pkg::CPD_ST_STOPPED;
        end
      end
      default: begin
        next_run_state = cpd_pkg::CPD_ST_STOPPED;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_state <= cpd_pkg::CPD_ST_STOPPED;
    end else begin
      run_state <= next_run_state;
    end
  end
  assign enabled = (run_state == cpd_pkg::CPD_ST_RUNNING);

  // drives gated by the live enable terms too, so stop bites without waiting for the state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      primary_drive_o    <= 1'b0;
      complement_drive_o <= 1'b0;
    end else begin
      primary_drive_o    <= enabled && stop && kill_sync && prim;
      complement_drive_o <= enabled && stop && kill_sync && comp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // checking helpers: length of the last period and whether settings moved during it
  logic [9:0] per_cyc;
  logic       cfg_moved;
  logic       seen_start;
  logic [9:0] exp_len;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      per_cyc    <= 10'h000;
      cfg_moved  <= 1'b1;
      seen_start <= 1'b0;
    end else if (period_start) begin
      per_cyc    <= 10'h001;
      cfg_moved  <= wr_ctrl; // a write on the start edge spoils the new period too
      seen_start <= 1'b1;
    end else begin
      per_cyc <= per_cyc + 10'h001;
      if (wr_ctrl) begin
        cfg_moved <= 1'b1;
      end
    end
  end
  assign exp_len = (res8 ? `CPD_LEN_8BIT : `CPD_LEN_7BIT) << div;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_period_length: assert property (
    period_start && seen_start && !cfg_moved |-> per_cyc == exp_len)
    else $error("pwm period length wrong for resolution and prescale");
  a_prescale_tick: assert property (
    tick && div ##1 div |-> !tick)
    else $error("prescaled counter advanced on consecutive clocks");
  a_stop_forces_off: assert property (
    !stop || !kill_sync |=> !primary_drive_o && !complement_drive_o)
    else $error("drive stayed on while stopped");
  a_reenable_start: assert property (
    $rose(enabled) |-> $past(period_start) && $past(stop) && $past(kill_sync))
    else $error("drives re-enabled away from a period start");
  a_no_overlap: assert property (
    !(primary_drive_o && complement_drive_o))
    else $error("both drives on together");
  a_full_duty_steady: assert property (
    (duty_eff == `CPD_CNT_TOP_8BIT) && res8 && enabled && stop && kill_sync && prim
      ##1 (duty_eff == `CPD_CNT_TOP_8BIT) && res8 |-> primary_drive_o ##1 prim)
    else $error("full duty produced a gap");
  a_duty_compare: assert property (
    res8 && duty_eff > 8'h01 && duty_eff < `CPD_CNT_TOP_8BIT |-> raw == (count < duty_eff))
    else $error("comparator disagrees with duty word");
  a_mid_period_change: assert property (
    $changed(duty_eff) && !period_start && res8 && duty_eff > 8'h01 && duty_eff < `CPD_CNT_TOP_8BIT
      |-> raw == (count < duty_eff))
    else $error("duty change not applied within the period");
  a_flat_extremes: assert property (
    res8 && (duty_eff <= 8'h01 || duty_eff == `CPD_CNT_TOP_8BIT)
      |-> raw == (duty_eff == `CPD_CNT_TOP_8BIT))
    else $error("flat duty word did not give a flat comparator level");
  a_seven_bit_compare: assert property (
    !res8 && !duty_eff[7] && duty_eff[6:0] > 7'h01 && duty_eff[6:0] < 7'h7f
      |-> raw == (count[6:0] < duty_eff[6:0]))
    else $error("seven-bit comparator disagrees with duty word");
  a_count_range: assert property (
    !res8 && count <= `CPD_CNT_TOP_7BIT ##1 !res8 |-> count <= `CPD_CNT_TOP_7BIT)
    else $error("seven-bit counter left its range");
  a_undivided_step: assert property (
    !div && !$past(div) && count != 8'h00 |-> count == $past(count) + 8'h01)
    else $error("undivided counter did not advance every clock");
  a_kill_sync: assert property (
    !$past(rst_i, 2) |-> kill_sync == $past(kill_n_i, 2))
    else $error("kill input not seen two clocks after the pin");

  c_div512: cover property (period_start && res8 && div && seen_start && !cfg_moved);
  c_div128: cover property (period_start && !res8 && !div && seen_start && !cfg_moved);
  c_reenable: cover property ($rose(enabled));
  c_deadtime_gap: cover property ($fell(complement_drive_o) ##[1:20] $rose(primary_drive_o));
endmodule // cpd_top

// File: src/cpd_cfg.svh
// Purpose: constants of the complementary pwm block: offsets, field positions, reset values, counts
// Assumes: included by bare name from every module file
// Notes:   definitions only
`ifndef CPD_CFG_SVH
`define CPD_CFG_SVH

// register port offsets
`define CPD_ADDR_DUTY     2'h0
`define CPD_ADDR_CTRL     2'h1
`define CPD_ADDR_STATUS   2'h2
`define CPD_ADDR_COUNT    2'h3

// control latch field positions
`define CPD_DT_LSB        0
`define CPD_DT_MSB        2
`define CPD_BIT_DIV       3
`define CPD_BIT_RSVD      4
`define CPD_BIT_LOCK      5
`define CPD_BIT_RES8      6
`define CPD_BIT_STOP      7

// reset values
`define CPD_CTRL_RESET    8'h47
`define CPD_DUTY_RESET    8'h00

// timing
`define CPD_CLK_PERIOD_NS 25
`define CPD_DT_UNIT_CYC   4'h2
`define CPD_DT_MAX_CYC    4'he
`define CPD_LEN_7BIT      10'h080
`define CPD_LEN_8BIT      10'h100
`define CPD_CNT_TOP_7BIT  8'h7f
`define CPD_CNT_TOP_8BIT  8'hff
`define CPD_DUTY_PIPE     3

`endif

// File: src/cpd_pkg.sv
// Purpose: shared types of the complementary pwm block
// Assumes: nothing
// Notes:   constants live in cpd_cfg.svh
package cpd_pkg;
  typedef logic [7:0] cpd_byte_t;
  // output enable state, one-hot
  typedef enum logic [1:0] {
    CPD_ST_STOPPED = 2'b01,
    CPD_ST_RUNNING = 2'b10
  } cpd_run_e;
endpackage

// File: src/cpd_deadtime.sv
// Purpose: turns the raw comparator level into two non-overlapping drives with dead-time
// Assumes: raw_i comes from logic on clk_i
// Notes:   drives are registered; gating for stop is done by the caller
`timescale 1ns/1ps
`include "cpd_cfg.svh"
module cpd_deadtime (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       raw_i,
  input  wire logic [2:0] code_i,
  output logic            prim_o,
  output logic            comp_o
);
  logic       target;
  logic [3:0] cnt;
  logic [3:0] off_run;
  logic [2:0] gap_code;

  // with a nonzero code a change of the raw level turns both off, then the new side on after the gap; code 0 switches at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      target <= 1'b0;
      cnt    <= `CPD_DT_MAX_CYC;
      prim_o <= 1'b0;
      comp_o <= 1'b0;
    end else if (raw_i != target) begin
      target <= raw_i;
      if (code_i == 3'h0) begin
        prim_o <= raw_i;
        comp_o <= ~raw_i;
        cnt    <= 4'h0;
      end else begin
        // a change inside the gap restarts it, so a short pulse never shows
        cnt    <= {1'b0, code_i} * `CPD_DT_UNIT_CYC;
        prim_o <= 1'b0;
        comp_o <= 1'b0;
      end
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
        prim_o <= target;
        comp_o <= ~target;
      end
    end
  end

  // helper: length of the current both-off run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      off_run <= 4'h0;
    end else if (prim_o || comp_o) begin
      off_run <= 4'h0;
    end else if (off_run != 4'hf) begin
      off_run <= off_run + 4'h1;
    end
  end

  // helper: code that loaded the running gap, so a code write mid-gap is judged fairly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gap_code <= 3'h7;
    end else if (raw_i != target) begin
      gap_code <= code_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_gap_length: assert property (
    ($rose(prim_o) || $rose(comp_o)) && !$past(rst_i, 15)
      |-> off_run >= {1'b0, gap_code} * `CPD_DT_UNIT_CYC)
    else $error("dead-time gap shorter than programmed");
  a_zero_code_pass: assert property (
    (code_i == 3'h0) && (raw_i != target) |=> (prim_o == $past(raw_i)) && (comp_o != prim_o))
    else $error("zero dead-time code did not pass the level through");
  a_settled_inverse: assert property (
    (cnt == 4'h0) && (raw_i == target) && (prim_o || comp_o) |-> comp_o == ~prim_o)
    else $error("complement drive is not the inverse when settled");
endmodule // cpd_deadtime

// File: src/cpd_ctrl_regs.sv
// Purpose: control latch with lock protection, and the duty word latch with its latency pipe
// Assumes: one-cycle write strobe from the register port
// Notes:   duty_eff_o lags the duty latch by three clocks
`timescale 1ns/1ps
`include "cpd_cfg.svh"
module cpd_ctrl_regs (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wr_ctrl_i,
  input  wire logic             wr_duty_i,
  input  wire cpd_pkg::cpd_byte_t wdata_i,
  output cpd_pkg::cpd_byte_t    ctrl_o,
  output cpd_pkg::cpd_byte_t    duty_o,
  output cpd_pkg::cpd_byte_t    duty_eff_o
);
  cpd_pkg::cpd_byte_t cap;
  logic               cap_v;
  cpd_pkg::cpd_byte_t pipe [`CPD_DUTY_PIPE];

  // control latch: whole byte at once with the reserved bit cleared when unlocked, only stop when locked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_o <= `CPD_CTRL_RESET;
    end else if (wr_ctrl_i) begin
      if (ctrl_o[`CPD_BIT_LOCK]) begin
        ctrl_o[`CPD_BIT_STOP] <= wdata_i[`CPD_BIT_STOP];
      end else begin
        ctrl_o <= wdata_i & ~(8'h01 << `CPD_BIT_RSVD);
      end
    end
  end

  // duty write captured with no sync needed; latch loads the clock after the strobe
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap    <= `CPD_DUTY_RESET;
      cap_v  <= 1'b0;
      duty_o <= `CPD_DUTY_RESET;
    end else begin
      cap_v <= wr_duty_i;
      if (wr_duty_i) begin
        cap <= wdata_i;
      end
      if (cap_v) begin
        duty_o <= cap;
      end
    end
  end

  // three-clock pipe from latch to comparator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `CPD_DUTY_PIPE; i++) begin
        pipe[i] <= `CPD_DUTY_RESET;
      end
    end else begin
      pipe[0] <= duty_o;
      for (int i = 1; i < `CPD_DUTY_PIPE; i++) begin
        pipe[i] <= pipe[i-1];
      end
    end
  end
  assign duty_eff_o = pipe[`CPD_DUTY_PIPE-1];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_lock_sticky: assert property (
    ctrl_o[`CPD_BIT_LOCK] |=> ctrl_o[`CPD_BIT_LOCK])
    else $error("lock bit cleared without hard init");
  a_lock_guards: assert property (
    wr_ctrl_i && ctrl_o[`CPD_BIT_LOCK] |=> ctrl_o[6:0] == $past(ctrl_o[6:0])
      && ctrl_o[`CPD_BIT_STOP] == $past(wdata_i[`CPD_BIT_STOP]))
    else $error("locked control field changed or stop not written");
  a_init_values: assert property (
    $past(rst_i) |-> ctrl_o == `CPD_CTRL_RESET && duty_o == `CPD_DUTY_RESET && duty_eff_o == `CPD_DUTY_RESET)
    else $error("hard init did not load the reset values");
  a_duty_latency: assert property (
    wr_duty_i |-> ##2 duty_o == $past(wdata_i, 2) ##3 duty_eff_o == $past(wdata_i, 5))
    else $error("duty word latency is wrong");
  c_lock_write: cover property (wr_ctrl_i && !ctrl_o[`CPD_BIT_LOCK] && wdata_i[`CPD_BIT_LOCK]);
endmodule // cpd_ctrl_regs

// File: bench/cpd_host_model.sv
// Purpose: processor-side model that writes and reads the pwm latches over the plain register port
// Assumes: one clock; every signal changes by non-blocking assignment just after a rising edge
// Notes:   released write data show the inverse of the last byte, so stale data cannot pass for fresh
`timescale 1ns/1ps
`include "cpd_cfg.svh"
module cpd_host_model (
  input  wire logic               clk_i,
  input  wire cpd_pkg::cpd_byte_t rdata_i,
  output logic [1:0]              addr_o,
  output cpd_pkg::cpd_byte_t      wdata_o,
  output logic                    wr_o,
  output logic                    rd_o
);
  // idle bus at time zero
  initial begin
    addr_o = 2'h0;
    wdata_o = 8'h5a;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // one-cycle write strobe beside address and data
  task automatic wr_reg(input logic [1:0] a, input cpd_pkg::cpd_byte_t d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [1:0] a, output cpd_pkg::cpd_byte_t d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask

  // computed duty is clamped to the range of the chosen resolution
  task automatic put_duty(input int v, input logic res8);
    int top;
    top = res8 ? 255 : 127;
    wr_reg(`CPD_ADDR_DUTY, cpd_pkg::cpd_byte_t'(v < 0 ? 0 : (v > top ? top : v)));
  endtask

  // safe duty goes in before the control byte, lock set by the caller's byte
  task automatic init(input cpd_pkg::cpd_byte_t ctrl);
    wr_reg(`CPD_ADDR_DUTY, 8'h00);
    wr_reg(`CPD_ADDR_CTRL, ctrl);
  endtask
endmodule // cpd_host_model

// File: bench/test_cpd_top.sv
// Purpose: self-checking bench of the complementary pwm block
// Assumes: host model drives the register port; the kill pin is driven here
// Notes:   waveforms are sampled at falling edges and measured between primary rising edges or over a fixed 512-clock window
`timescale 1ns/1ps
`include "cpd_cfg.svh"
module test_cpd_top;
  typedef struct {
    cpd_pkg::cpd_byte_t ctrl;
    cpd_pkg::cpd_byte_t duty;
    int                 p;
    int                 hp;
  } cpd_row_s;
  logic               clk;
  logic               rst;
  logic               kill_n;
  logic [1:0]         addr;
  cpd_pkg::cpd_byte_t wdata;
  logic               wr;
  logic               rd;
  cpd_pkg::cpd_byte_t rdata;
  logic               prim;
  logic               comp;
  int                 n_fail;
  int                 n_checks;
  int                 n;
  int                 hp;
  int                 hc;
  int                 ov;
  cpd_pkg::cpd_byte_t v;
  cpd_row_s           rows [4];

  cpd_host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  cpd_top DUT (.clk_i(clk), .rst_i(rst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .kill_n_i(kill_n), .rdata_o(rdata), .primary_drive_o(prim), .complement_drive_o(comp));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic done(input string name);
    $display("test %s finished at %0t", name, $time);
  endtask

  // three spans between primary rises; the first two may hold enable transients
  task automatic meas();
    logic pv;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      hp = 0;
      hc = 0;
      ov = 0;
      do begin
        pv = prim;
        @(negedge clk);
        n++;
        hp += int'(prim === 1'b1);
        hc += int'(comp === 1'b1);
        ov += int'((prim & comp) === 1'b1);
        if (n > 1200) begin
          n_fail++;
          $display("CHECK FAILED at %0t: no primary rise", $time);
          stop_test();
        end
      end while (!(pv === 1'b0 && prim === 1'b1));
    end
  endtask

  // settle, then count high samples over 512 clocks
  task automatic lvl();
    hp = 0;
    hc = 0;
    repeat (600) @(negedge clk);
    repeat (512) begin
      @(negedge clk);
      hp += int'(prim === 1'b1);
      hc += int'(comp === 1'b1);
    end
  endtask

  task automatic hard_init();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    kill_n = 1'b1;
    n_fail = 0;
    n_checks = 0;
    rows = '{'{8'hc0, 8'h40, 256, 64}, '{8'hc8, 8'h40, 512, 128}, '{8'h80, 8'h20, 128, 32},
      '{8'h88, 8'h20, 256, 64}};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    host.rd_reg(`CPD_ADDR_CTRL, v);
    check(v, 8'h47);
    host.rd_reg(`CPD_ADDR_DUTY, v);
    check(v, 8'h00);
    host.rd_reg(`CPD_ADDR_STATUS, v);
    check(v, 8'h02);
    check({prim, comp}, 2'b00);
    done("reset");
    // resolution and prescale table, no dead-time
    foreach (rows[i]) begin
      host.put_duty(int'(rows[i].duty), rows[i].ctrl[`CPD_BIT_RES8]);
      host.wr_reg(`CPD_ADDR_CTRL, rows[i].ctrl);
      meas();
      check(n, rows[i].p);
      check(hp, rows[i].hp);
      check(hc, rows[i].p - rows[i].hp);
      check(ov, 0);
    end
    done("table");
    // every dead-time code, two clocks a unit off each on-time
    host.put_duty(64, 1'b1);
    for (int c = 0; c < 8; c++) begin
      host.wr_reg(`CPD_ADDR_CTRL, 8'hc0 | c[7:0]);
      meas();
      check(hp, 64 - 2 * c);
      check(hc, 192 - 2 * c);
      check(n - hp - hc, 4 * c);
      check(ov, 0);
    end
    done("dead-time codes");
    // lock: one write sets everything, then only stop moves
    hard_init();
    host.init(8'he3);
    host.rd_reg(`CPD_ADDR_CTRL, v);
    check(v, 8'he3);
    lvl();
    check(hc, 512);
    host.wr_reg(`CPD_ADDR_CTRL, 8'h40);
    repeat (3) @(negedge clk);
    check({prim, comp}, 2'b00);
    host.rd_reg(`CPD_ADDR_CTRL, v);
    check(v, 8'h63);
    host.wr_reg(`CPD_ADDR_CTRL, 8'h80);
    host.wr_reg(`CPD_ADDR_STATUS, 8'h00);
    host.rd_reg(`CPD_ADDR_CTRL, v);
    check(v, 8'he3);
    hard_init();
    host.rd_reg(`CPD_ADDR_CTRL, v);
    check(v, 8'h47);
    done("lock");
    // extremes at maximum dead-time, kill pin in between
    host.init(8'hc7);
    lvl();
    check(hp, 0);
    check(hc, 512);
    host.put_duty(255, 1'b1);
    lvl();
    check(hp, 512);
    check(hc, 0);
    @(posedge clk);
    kill_n <= 1'b0;
    repeat (5) @(negedge clk);
    check({prim, comp}, 2'b00);
    @(posedge clk);
    kill_n <= 1'b1;
    lvl();
    check(hp, 512);
    host.put_duty(8, 1'b1);
    lvl();
    check(hp, 0);
    check(hc, 468);
    done("extremes");
    // latency of a duty write landing at an arbitrary point of the period
    host.wr_reg(`CPD_ADDR_CTRL, 8'hc0);
    host.put_duty(0, 1'b1);
    lvl();
    host.put_duty(255, 1'b1);
    repeat (6) @(negedge clk);
    check(prim, 1'b0);
    @(negedge clk);
    check(prim, 1'b1);
    done("latency");
    stop_test();
  end
endmodule // test_cpd_top
